// file: logic/bit_call_alu.sv
// bit test data path: reports and modifies the selected bit
`timescale 1ns/1ps
module bit_call_alu (
    input  wire logic [31:0] i_operand,
    input  wire logic [4:0]  i_bit_sel,
    input  wire logic [3:0]  i_op,
    output logic      [31:0] o_result,
    output logic             o_bit
);
    wire logic [31:0] mask = 32'h1 << i_bit_sel;
    assign o_bit = |(i_operand & mask);
    always_comb begin
        case (i_op)
            bit_call_pkg::OP_COMPL: o_result = i_operand ^ mask;  // RULE_03
            bit_call_pkg::OP_CLEAR: o_result = i_operand & ~mask; // RULE_05
            bit_call_pkg::OP_SET:   o_result = i_operand | mask;  // RULE_07
            default:                o_result = i_operand;
        endcase
    end
endmodule : bit_call_alu

// file: logic/bit_call_decode.sv
// decoder and clock sequencer for bit test and call instructions
//
// Behaviour
// RULE_01 - 0F BA /4 imm: bit test, 3/6
// RULE_02 - 0F A3: bit test by register, 3/12
// RULE_03 - 0F BA /7: complement bit, 6/8
// RULE_04 - 0F BB: complement by register, 6/13
// RULE_05 - 0F BA /6: clear bit, 6/8
// RULE_06 - 0F B3: clear by register, 6/13
// RULE_07 - 0F BA /5: set bit, 6/8
// RULE_08 - 0F AB: set by register, 6/13
// RULE_09 - near direct call: 7 or 9 plus m
// RULE_10 - FF /2 indirect call: 7/10 or 9/12
// RULE_11 - far direct call: 17 or 42 plus m
// RULE_12 - same level gate call: 64 plus m
// RULE_13 - other level gate: 98, or 106+8x
// RULE_14 - v86 port denied: fault vector 13
// RULE_15 - add one cycle per fetched component
// RULE_16 - pair: register first, memory second
`timescale 1ns/1ps
module bit_call_decode (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_op0,
    input  wire logic [7:0]  i_op1,
    input  wire logic [7:0]  i_modrm,
    input  wire logic [7:0]  i_imm,
    input  wire logic [31:0] i_operand,
    input  wire logic [31:0] i_bit_reg,
    input  wire logic        i_prot_mode,
    input  wire logic        i_v86_mode,
    input  wire logic        i_gate,
    input  wire logic        i_gate_diff_pl,
    input  wire logic [4:0]  i_param_cnt,
    input  wire logic [3:0]  i_fetch_comps,
    input  wire logic        i_io_access,
    input  wire logic        i_io_permit,
    output logic             o_busy,
    output logic             o_done,
    output logic [3:0]       o_op,
    output logic [7:0]       o_clocks,
    output logic [31:0]      o_result,
    output logic             o_carry,
    output logic             o_fault,
    output logic [7:0]       o_fault_vec,
    output logic             o_illegal
);
    // ==========================================================
    // decode
    wire logic       is_esc  = (i_op0 == bit_call_pkg::ESC_BYTE);
    wire logic [2:0] ext     = i_modrm[5:3];
    wire logic       mem_opd = (i_modrm[7:6] != bit_call_pkg::MOD_REG);
    wire logic       imm_grp =
        is_esc && (i_op1 == bit_call_pkg::OPC_TEST_IMM);
    wire logic       tst_imm =
        imm_grp && ext == bit_call_pkg::EXT_TEST;               // RULE_01
    wire logic       cpl_imm =
        imm_grp && ext == bit_call_pkg::EXT_COMPL;              // RULE_03
    wire logic       clr_imm =
        imm_grp && ext == bit_call_pkg::EXT_CLEAR;              // RULE_05
    wire logic       set_imm =
        imm_grp && ext == bit_call_pkg::EXT_SET;                // RULE_07
    wire logic       tst_reg =
        is_esc && i_op1 == bit_call_pkg::OPC_TEST_REG;          // RULE_02
    wire logic       cpl_reg =
        is_esc && i_op1 == bit_call_pkg::OPC_COMPL_REG;         // RULE_04
    wire logic       clr_reg =
        is_esc && i_op1 == bit_call_pkg::OPC_CLEAR_REG;         // RULE_06
    wire logic       set_reg =
        is_esc && i_op1 == bit_call_pkg::OPC_SET_REG;           // RULE_08
    wire logic       c_near  =
        (i_op0 == bit_call_pkg::OPC_CALL_NEAR);                 // RULE_09
    wire logic       c_ind   =
        (i_op0 == bit_call_pkg::OPC_GRP_FF)
        && ext == bit_call_pkg::EXT_CALL_IND;                   // RULE_10
    wire logic       c_far   =
        (i_op0 == bit_call_pkg::OPC_CALL_FAR);                  // RULE_11
    // gates exist only in protected mode
    wire logic       gate_ok = c_far && i_gate && i_prot_mode;  // RULE_12
    wire logic       pm      = i_prot_mode && !i_v86_mode;
    wire logic       io_deny =
        i_v86_mode && i_io_access && !i_io_permit;              // RULE_14

    wire logic [3:0] dec_op =
        (tst_imm || tst_reg) ? bit_call_pkg::OP_TEST  :
        (cpl_imm || cpl_reg) ? bit_call_pkg::OP_COMPL :
        (clr_imm || clr_reg) ? bit_call_pkg::OP_CLEAR :
        (set_imm || set_reg) ? bit_call_pkg::OP_SET   :
        c_near ? bit_call_pkg::OP_CNEAR :
        c_ind  ? bit_call_pkg::OP_CIND  :
        c_far  ? bit_call_pkg::OP_CFAR  : bit_call_pkg::OP_NONE;

    // ==========================================================
    // base clock counts
    // limitation: counts above 255 wrap, so large parameter lists alias
    wire logic [7:0] param_clk =
        {3'h0, i_param_cnt} * bit_call_pkg::CLK_PER_PARAM;
    wire logic [7:0] gate_clk  =
        !i_gate_diff_pl ? bit_call_pkg::CLK_GATE_SAME :         // RULE_12
        (i_param_cnt == 5'h00) ? bit_call_pkg::CLK_GATE_DIFF0 : // RULE_13
        8'(bit_call_pkg::CLK_GATE_DIFFX + param_clk);           // RULE_13
    wire logic [7:0] base_clk =                                 // RULE_16
        tst_imm ? bit_call_pkg::pick(mem_opd,
            bit_call_pkg::CLK_TEST_IMM_R, bit_call_pkg::CLK_TEST_IMM_M) :
        tst_reg ? bit_call_pkg::pick(mem_opd,
            bit_call_pkg::CLK_TEST_REG_R, bit_call_pkg::CLK_TEST_REG_M) :
        (cpl_imm || clr_imm || set_imm) ? bit_call_pkg::pick(mem_opd,
            bit_call_pkg::CLK_BXX_IMM_R, bit_call_pkg::CLK_BXX_IMM_M) :
        (cpl_reg || clr_reg || set_reg) ? bit_call_pkg::pick(mem_opd,
            bit_call_pkg::CLK_BXX_REG_R, bit_call_pkg::CLK_BXX_REG_M) :
        c_near ? bit_call_pkg::pick(pm,
            bit_call_pkg::CLK_NEAR_RL, bit_call_pkg::CLK_NEAR_PM) :
        (c_ind && mem_opd) ? bit_call_pkg::pick(pm,
            bit_call_pkg::CLK_IND_M_RL, bit_call_pkg::CLK_IND_M_PM) :
        c_ind ? bit_call_pkg::pick(pm,
            bit_call_pkg::CLK_IND_R_RL, bit_call_pkg::CLK_IND_R_PM) :
        gate_ok ? gate_clk :
        c_far ? bit_call_pkg::pick(pm,
            bit_call_pkg::CLK_FAR_RL, bit_call_pkg::CLK_FAR_PM) : 8'h01;
    wire logic       is_xfer   = c_near || c_ind || c_far;
    wire logic [7:0] total_clk = is_xfer ?                      // RULE_15
        8'(base_clk + {4'h0, i_fetch_comps}) : base_clk;

    // ==========================================================
    // bit data path; register forms take offset from a register
    wire logic [4:0]  bit_sel = imm_grp ? i_imm[4:0] : i_bit_reg[4:0];
    wire logic [31:0] alu_res;
    wire logic        alu_bit;
    bit_call_alu u_alu (
        .i_operand (i_operand),
        .i_bit_sel (bit_sel),
        .i_op      (dec_op),
        .o_result  (alu_res),
        .o_bit     (alu_bit)
    );

    // ==========================================================
    // sequencer: holds for the decoded number of clocks
    bit_call_pkg::state_t state_ff, nxt_state;
    logic [7:0] cnt_ff;
    logic [7:0] clocks_ff;
    wire logic  accept = (state_ff == bit_call_pkg::ST_IDLE) && i_start;
    wire logic  bad    = (dec_op == bit_call_pkg::OP_NONE) || io_deny;

    always_comb begin
        case (state_ff)
            bit_call_pkg::ST_IDLE: nxt_state = (accept && !bad) ?
                (total_clk == 8'h01 ? bit_call_pkg::ST_DONE
                                    : bit_call_pkg::ST_RUN)
                : bit_call_pkg::ST_IDLE;
            bit_call_pkg::ST_RUN:  nxt_state = (cnt_ff == 8'h02) ?
                bit_call_pkg::ST_DONE : bit_call_pkg::ST_RUN;
            default:               nxt_state = bit_call_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff    <= bit_call_pkg::ST_IDLE;
            cnt_ff      <= 8'h00;
            clocks_ff   <= 8'h00;
            o_op        <= 4'h0;
            o_result    <= 32'h0;
            o_carry     <= 1'b0;
            o_fault     <= 1'b0;
            o_fault_vec <= 8'h00;
            o_illegal   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            o_fault   <= accept && io_deny;                         // RULE_14
            o_illegal <= accept && !io_deny
                         && dec_op == bit_call_pkg::OP_NONE;
            if (accept && io_deny) begin
                o_fault_vec <= bit_call_pkg::GP_FAULT_VECTOR;       // RULE_14
            end
            if (accept && !bad) begin
                cnt_ff    <= total_clk;
                clocks_ff <= total_clk;
                o_op      <= dec_op;
                o_result  <= alu_res;
                o_carry   <= alu_bit;
            end else if (state_ff == bit_call_pkg::ST_RUN) begin
                cnt_ff <= 8'(cnt_ff - 8'h01);
            end
        end
    end

    assign o_busy   = (state_ff != bit_call_pkg::ST_IDLE);
    assign o_done   = (state_ff == bit_call_pkg::ST_DONE);
    assign o_clocks = clocks_ff;

    // ==========================================================
    // checks
    AST_DONE_AFTER_COUNT: assert property (@(posedge i_ref_clk) // RULE_15
        disable iff (!i_resetn)
        (state_ff == bit_call_pkg::ST_RUN && cnt_ff == 8'h02)
        |=> o_done)
        else $error("done did not follow count end");
    AST_NEAR_PM_CLOCKS: assert property (@(posedge i_ref_clk) // RULE_09
        disable iff (!i_resetn)
        (accept && c_near && pm && !io_deny)
        |=> o_clocks == 8'(8'h09 + {4'h0, $past(i_fetch_comps)}))
        else $error("near call clock count wrong");
    AST_TEST_IMM_MEM: assert property (@(posedge i_ref_clk) // RULE_01
        disable iff (!i_resetn)
        (accept && tst_imm && mem_opd && !io_deny)
        |=> o_clocks == 8'h06)
        else $error("bit test memory count wrong");
    AST_TEST_REG_MEM: assert property (@(posedge i_ref_clk) // RULE_02
        disable iff (!i_resetn)
        (accept && tst_reg && mem_opd && !io_deny)
        |=> o_clocks == 8'h0C)
        else $error("bit test register offset count wrong");
    AST_COMPL_FLIP: assert property (@(posedge i_ref_clk) // RULE_03
        disable iff (!i_resetn)
        (accept && cpl_imm && !io_deny)
        |=> o_result == ($past(i_operand) ^ (32'h1 << $past(i_imm[4:0]))))
        else $error("complement result wrong");
    AST_CLEAR_BIT: assert property (@(posedge i_ref_clk) // RULE_06
        disable iff (!i_resetn)
        (accept && clr_reg && !io_deny)
        |=> o_result[$past(i_bit_reg[4:0])] == 1'b0)
        else $error("clear left bit set");
    AST_SET_BIT: assert property (@(posedge i_ref_clk) // RULE_08
        disable iff (!i_resetn)
        (accept && set_reg && !mem_opd && !io_deny)
        |=> o_result[$past(i_bit_reg[4:0])] && o_clocks == 8'h06)
        else $error("set result or count wrong");
    AST_GATE_DIFF: assert property (@(posedge i_ref_clk) // RULE_13
        disable iff (!i_resetn)
        (accept && gate_ok && i_gate_diff_pl && i_param_cnt == 5'h00
         && !io_deny)
        |=> o_clocks == 8'(8'h62 + {4'h0, $past(i_fetch_comps)}))
        else $error("gate call count wrong");
    AST_FAULT_VEC: assert property (@(posedge i_ref_clk) // RULE_14
        disable iff (!i_resetn)
        (accept && io_deny)
        |=> o_fault && o_fault_vec == 8'h0D && !o_busy)
        else $error("denied port did not fault");
endmodule : bit_call_decode

// file: logic/bit_call_pkg.sv
// constants and types for the bit test and call decoder
package bit_call_pkg;
    localparam logic [7:0] ESC_BYTE        = 8'h0F;
    localparam logic [7:0] OPC_TEST_IMM    = 8'hBA;
    localparam logic [7:0] OPC_TEST_REG    = 8'hA3;
    localparam logic [7:0] OPC_COMPL_REG   = 8'hBB;
    localparam logic [7:0] OPC_CLEAR_REG   = 8'hB3;
    localparam logic [7:0] OPC_SET_REG     = 8'hAB;
    localparam logic [7:0] OPC_CALL_NEAR   = 8'hE8;
    localparam logic [7:0] OPC_GRP_FF      = 8'hFF;
    localparam logic [7:0] OPC_CALL_FAR    = 8'h9A;
    localparam logic [2:0] EXT_TEST        = 3'h4;
    localparam logic [2:0] EXT_SET         = 3'h5;
    localparam logic [2:0] EXT_CLEAR       = 3'h6;
    localparam logic [2:0] EXT_COMPL       = 3'h7;
    localparam logic [2:0] EXT_CALL_IND    = 3'h2;
    localparam logic [1:0] MOD_REG         = 2'h3;
    localparam logic [7:0] GP_FAULT_VECTOR = 8'h0D;
    // base clock counts
    localparam logic [7:0] CLK_TEST_IMM_R  = 8'h03;
    localparam logic [7:0] CLK_TEST_IMM_M  = 8'h06;
    localparam logic [7:0] CLK_TEST_REG_R  = 8'h03;
    localparam logic [7:0] CLK_TEST_REG_M  = 8'h0C;
    localparam logic [7:0] CLK_BXX_IMM_R   = 8'h06;
    localparam logic [7:0] CLK_BXX_IMM_M   = 8'h08;
    localparam logic [7:0] CLK_BXX_REG_R   = 8'h06;
    localparam logic [7:0] CLK_BXX_REG_M   = 8'h0D;
    localparam logic [7:0] CLK_NEAR_RL     = 8'h07;
    localparam logic [7:0] CLK_NEAR_PM     = 8'h09;
    localparam logic [7:0] CLK_IND_R_RL    = 8'h07;
    localparam logic [7:0] CLK_IND_R_PM    = 8'h09;
    localparam logic [7:0] CLK_IND_M_RL    = 8'h0A;
    localparam logic [7:0] CLK_IND_M_PM    = 8'h0C;
    localparam logic [7:0] CLK_FAR_RL      = 8'h11;
    localparam logic [7:0] CLK_FAR_PM      = 8'h2A;
    localparam logic [7:0] CLK_GATE_SAME   = 8'h40;
    localparam logic [7:0] CLK_GATE_DIFF0  = 8'h62;
    localparam logic [7:0] CLK_GATE_DIFFX  = 8'h6A;
    localparam logic [7:0] CLK_PER_PARAM   = 8'h08;

    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_TEST  = 4'h1,
        OP_COMPL = 4'h2,
        OP_CLEAR = 4'h3,
        OP_SET   = 4'h4,
        OP_CNEAR = 4'h5,
        OP_CIND  = 4'h6,
        OP_CFAR  = 4'h7
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } state_t;

    function automatic logic [7:0] pick(input logic sel,
                                        input logic [7:0] a,
                                        input logic [7:0] b);
        pick = sel ? b : a;
    endfunction : pick
endpackage : bit_call_pkg

// file: tb/tb_top.sv
// self-checking bench for the bit test and call decoder
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        logic [1:0]  kind;
        logic [3:0]  op;
        logic [7:0]  clk;
        logic [31:0] res;
        logic        car;
        logic        data;
        int          acc;
    } note_t;

    // ==========================================================
    // stimulus and observed signals
    logic        i_ref_clk      = 1'b0;
    logic        i_resetn       = 1'b0;
    logic        i_start        = 1'b0;
    logic [7:0]  i_op0          = 8'h00;
    logic [7:0]  i_op1          = 8'h00;
    logic [7:0]  i_modrm        = 8'h00;
    logic [7:0]  i_imm          = 8'h00;
    logic [31:0] i_operand      = 32'h0;
    logic [31:0] i_bit_reg      = 32'h0;
    logic        i_prot_mode    = 1'b0;
    logic        i_v86_mode     = 1'b0;
    logic        i_gate         = 1'b0;
    logic        i_gate_diff_pl = 1'b0;
    logic [4:0]  i_param_cnt    = 5'h0;
    logic [3:0]  i_fetch_comps  = 4'h0;
    logic        i_io_access    = 1'b0;
    logic        i_io_permit    = 1'b0;
    logic        o_busy, o_done, o_carry, o_fault, o_illegal;
    logic [3:0]  o_op;
    logic [7:0]  o_clocks, o_fault_vec;
    logic [31:0] o_result;
    note_t       q[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          resp      = 0;

    bit_call_decode i_bit_call_decode (.i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn), .i_start(i_start), .i_op0(i_op0),
        .i_op1(i_op1), .i_modrm(i_modrm), .i_imm(i_imm),
        .i_operand(i_operand), .i_bit_reg(i_bit_reg),
        .i_prot_mode(i_prot_mode), .i_v86_mode(i_v86_mode),
        .i_gate(i_gate), .i_gate_diff_pl(i_gate_diff_pl),
        .i_param_cnt(i_param_cnt), .i_fetch_comps(i_fetch_comps),
        .i_io_access(i_io_access), .i_io_permit(i_io_permit),
        .o_busy(o_busy), .o_done(o_done), .o_op(o_op),
        .o_clocks(o_clocks), .o_result(o_result), .o_carry(o_carry),
        .o_fault(o_fault), .o_fault_vec(o_fault_vec),
        .o_illegal(o_illegal));

    // ==========================================================
    // clock, cycle count and hang limit
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // monitor: #1 past the edge so registered outputs have landed
    always @(posedge i_ref_clk) begin
        note_t n;
        #1;
        if (o_done === 1'b1 || o_fault === 1'b1 || o_illegal === 1'b1) begin
            resp++;
            if (q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                n = q.pop_front();
                check(32'({o_done, o_fault, o_illegal}),
                      32'(3'h4 >> n.kind));
                if (n.kind == 2'h0) begin
                    check(32'(o_op), 32'(n.op));
                    check(32'(o_clocks), 32'(n.clk));
                    check(cyc - n.acc, 32'(n.clk) - 1);
                    if (n.data) begin
                        check(o_result, n.res);
                        check(32'(o_carry), 32'(n.car));
                    end
                end else if (n.kind == 2'h1) begin
                    check(32'(o_fault_vec), 32'h0D);
                end
            end
        end
    end

    // ==========================================================
    // drivers: called at a falling edge, return one cycle past the result
    task automatic go(input note_t n, input bit poke);
        int r0;
        r0 = resp;
        n.acc = cyc + 1;
        q.push_back(n);
        i_start = 1'b1;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        check(32'(o_busy), 32'(n.kind == 2'h0));
        if (poke) begin
            repeat (3) @(negedge i_ref_clk);
            i_start = 1'b1;
            @(negedge i_ref_clk);
            i_start = 1'b0;
        end
        for (int i = 0; i < 300 && resp == r0; i++) @(negedge i_ref_clk);
        check(32'(resp != r0), 32'h1);
        @(negedge i_ref_clk);
    endtask : go

    task automatic bit_op(input int k, input bit by_reg, input bit mem);
        note_t       n;
        logic [4:0]  sel;
        logic [31:0] msk;
        logic [2:0]  ext_tab [4] = '{3'h4, 3'h7, 3'h6, 3'h5};
        logic [7:0]  opc_tab [4] = '{8'hA3, 8'hBB, 8'hB3, 8'hAB};
        i_operand = $urandom;
        i_bit_reg = $urandom;
        i_imm = 8'($urandom);
        i_prot_mode = 1'($urandom);
        i_v86_mode = 1'($urandom);
        i_fetch_comps = 4'($urandom);
        i_op0 = 8'h0F;
        i_op1 = by_reg ? opc_tab[k]
                       : 8'hBA;
        i_modrm = {mem ? 2'($urandom_range(2)) : 2'h3,
                   by_reg ? 3'($urandom) : ext_tab[k], 3'($urandom)};
        sel = by_reg ? i_bit_reg[4:0] : i_imm[4:0];
        msk = 32'h1 << sel;
        n = '{2'h0, 4'(k + 1), 8'h0, i_operand, i_operand[sel], 1'b1, 0};
        n.res = k == 1 ? i_operand ^ msk : k == 2 ? i_operand & ~msk
              : k == 3 ? i_operand | msk : i_operand;
        n.clk = k == 0 ? (by_reg ? (mem ? 8'h0C : 8'h03)
                                 : (mem ? 8'h06 : 8'h03))
                       : (by_reg ? (mem ? 8'h0D : 8'h06)
                                 : (mem ? 8'h08 : 8'h06));
        go(n, 1'b0);
    endtask : bit_op

    task automatic call(input int k, input bit mem, input bit pm,
                        input bit v86, input bit gate, input bit diff,
                        input int x, input bit poke);
        note_t n;
        bit    p;
        int    b;
        i_op0 = k == 0 ? 8'hE8 : k == 1 ? 8'hFF : 8'h9A;
        i_modrm = {mem ? 2'h1 : 2'h3, 3'h2, 3'($urandom)};
        {i_prot_mode, i_v86_mode} = {pm, v86};
        {i_gate, i_gate_diff_pl} = {gate, diff};
        i_param_cnt = 5'(x);
        i_fetch_comps = 4'($urandom);
        p = pm && !v86;
        b = k == 0 ? (p ? 9 : 7)
          : k == 1 ? (mem ? (p ? 12 : 10) : (p ? 9 : 7))
          : !gate ? (p ? 42 : 17) : !diff ? 64
          : x == 0 ? 98 : 106 + 8 * x;
        n = '{2'h0, 4'(5 + k), 8'(b + i_fetch_comps), 32'h0, 1'b0, 1'b0, 0};
        go(n, poke);
    endtask : call

    // ==========================================================
    // main sequence
    initial begin
        note_t n;
        void'($urandom(32'hdee2));
        repeat (16) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_resetn = 1'b1;
        for (int k = 0; k < 4; k++)
            for (int f = 0; f < 4; f++) bit_op(k, f[1], f[0]);
        $display("test bit operations finished");
        for (int k = 0; k < 3; k++)
            for (int f = 0; f < 8; f++) call(k, f[0], f[1], f[2], 0, 0, 0, 0);
        call(2, 0, 1, 0, 1, 0, 0, 0);
        call(2, 0, 1, 0, 1, 1, 0, 0);
        call(2, 0, 1, 0, 1, 1, $urandom_range(16, 1), 1);
        $display("test calls and gates finished");
        i_io_access = 1'b1;
        i_io_permit = 1'b1;
        call(0, 0, 1, 1, 0, 0, 0, 0);
        i_io_permit = 1'b0;
        n = '{2'h1, 4'h0, 8'h0, 32'h0, 1'b0, 1'b0, 0};
        go(n, 1'b0);
        i_io_access = 1'b0;
        $display("test port permission finished");
        i_op0 = 8'hFF;
        i_modrm = {2'h3, 3'h3, 3'h0};
        n.kind = 2'h2;
        go(n, 1'b0);
        $display("test unknown opcode finished");
        check(32'(q.size()), 32'h0);
        wrap_up();
    end
endmodule : tb_top
